//--- rtl/pcu_position_capture.sv
// position capture unit: parameter port, status word and two capture channels
//
// Function
// - activation code 0 cancels, 1 starts a single capture, 2 starts continuous capture.
// - single capture stops after its first latch, continuous runs until cancelled.
// - capture may be armed only in fieldbus control mode and the master keeps to that.
// - edge select 0 captures on falling edge, 1 on rising edge, default 0.
// - a 16-bit event counter counts captures and clears whenever the unit is armed.
// - the captured value is the signed 32-bit actual position at the trigger.
// - the captured value follows each position-setting or homing change of reference, except one arriving in the cycle of a latch.
// - the read-only status word flags captures: bit 0 input 1, bit 1 input 2, bit 2 index.
// - the first capture unit behaves the same, clearing its own counter on arming.
`timescale 1ns/10ps
`include "pcu_map.svh"
module pcu_position_capture #(
   parameter int POS_W = 32,
   parameter int CNT_W = 16
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [15:0] parAddr,
   input wire logic parWrite,
   input wire logic parRead,
   input wire logic [31:0] parWdata,
   output logic [31:0] parRdata,
   output logic parAck,
   output logic parError,
   input wire logic first_capture_input,
   input wire logic second_capture_input,
   input wire logic indexCaptureDone,
   input wire logic fieldbusMode,
   input wire logic signed [POS_W-1:0] actualPosition,
   input wire logic posRefShiftValid,
   input wire logic signed [POS_W-1:0] posRefShift,
   output logic [1:0] capture1Mode,
   output logic [1:0] capture2Mode
);
   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   if (POS_W != 32 || CNT_W < 1 || CNT_W > 16) begin : g_bad_width
      $error("pcu_position_capture: unsupported width");
   end

   pcu_chan_if #(.POS_W(POS_W), .CNT_W(CNT_W)) c1 ();
   pcu_chan_if #(.POS_W(POS_W), .CNT_W(CNT_W)) c2 ();

   logic edgeSel1;
   logic edgeSel2;
   logic indexDone;
   logic act1Wr;
   logic act2Wr;
   logic codeValid;
   logic codeRefused;
   logic mapped;
   logic readOnly;
   logic [31:0] next_rdata;

   function automatic logic at(input logic [15:0] a, input logic [15:0] ofs);
      at = (a == ofs);
   endfunction

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   assign codeValid = (parWdata[15:0] == `PCU_CODE_STOP) || (parWdata[15:0] == `PCU_CODE_ONCE) ||
      (parWdata[15:0] == `PCU_CODE_CONT);
   assign codeRefused = !codeValid || (parWdata[15:0] != `PCU_CODE_STOP && !fieldbusMode);
   assign act1Wr = parWrite && at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_ACT) && codeValid;
   assign act2Wr = parWrite && at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_ACT) && codeValid;
   assign mapped = at(parAddr, `PCU_OFS_STATUS) || at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_EDGE) ||
      at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_EDGE) || at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_ACT) ||
      at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_ACT) || at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_POS) ||
      at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_POS) || at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_CNT) ||
      at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_CNT);
   assign readOnly = at(parAddr, `PCU_OFS_STATUS) || at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_POS) ||
      at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_POS) || at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_CNT) ||
      at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_CNT);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         edgeSel1 <= `PCU_RST_EDGE;
         edgeSel2 <= `PCU_RST_EDGE;
      end else if (parWrite && parWdata[15:1] == 15'h0000) begin
         if (at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_EDGE)) begin
            edgeSel1 <= parWdata[0];
         end
         if (at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_EDGE)) begin
            edgeSel2 <= parWdata[0];
         end
      end
   end

   // ------------------------------------------------------------
   // channel hookup
   // ------------------------------------------------------------
   assign c1.activateWr = act1Wr;
   assign c1.activateCode = parWdata[1:0];
   assign c1.fieldbusMode = fieldbusMode;
   assign c1.edgeSel = edgeSel1;
   assign c1.capIn = first_capture_input;
   assign c1.actualPos = actualPosition;
   assign c1.shiftValid = posRefShiftValid;
   assign c1.shift = posRefShift;
   assign c2.activateWr = act2Wr;
   assign c2.activateCode = parWdata[1:0];
   assign c2.fieldbusMode = fieldbusMode;
   assign c2.edgeSel = edgeSel2;
   assign c2.capIn = second_capture_input;
   assign c2.actualPos = actualPosition;
   assign c2.shiftValid = posRefShiftValid;
   assign c2.shift = posRefShift;

   pcu_capture_channel #(.POS_W(POS_W), .CNT_W(CNT_W)) u_first_capture_input (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ch(c1.chan)
   );
   pcu_capture_channel #(.POS_W(POS_W), .CNT_W(CNT_W)) u_second_capture_input (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .ch(c2.chan)
   );

   assign capture1Mode = c1.modeCode;
   assign capture2Mode = c2.modeCode;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         indexDone <= 1'h0;
      end else begin
         indexDone <= indexCaptureDone;
      end
   end

   // ------------------------------------------------------------
   // read mux and answer
   // ------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h00000000;
      if (at(parAddr, `PCU_OFS_STATUS)) begin
         next_rdata[`PCU_BIT_FIRST_CAPTURE_INPUT] = c1.done;
         next_rdata[`PCU_BIT_SECOND_CAPTURE_INPUT] = c2.done;
         next_rdata[`PCU_BIT_INDEX] = indexDone;
      end else if (at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_EDGE)) begin
         next_rdata[0] = edgeSel1;
      end else if (at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_EDGE)) begin
         next_rdata[0] = edgeSel2;
      end else if (at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_ACT)) begin
         next_rdata[1:0] = c1.modeCode;
      end else if (at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_ACT)) begin
         next_rdata[1:0] = c2.modeCode;
      end else if (at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_POS)) begin
         next_rdata = c1.position;
      end else if (at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_POS)) begin
         next_rdata = c2.position;
      end else if (at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_CNT)) begin
         next_rdata[CNT_W-1:0] = c1.count;
      end else if (at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_CNT)) begin
         next_rdata[CNT_W-1:0] = c2.count;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         parRdata <= 32'h00000000;
         parAck <= 1'h0;
         parError <= 1'h0;
      end else begin
         parAck <= parRead || parWrite;
         if (parRead) begin
            parRdata <= next_rdata;
            parError <= !mapped;
         end else if (parWrite) begin
            parError <= !mapped || readOnly ||
               ((at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_ACT) || at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_ACT)) && codeRefused) ||
               ((at(parAddr, `PCU_OFS_FIRST_CAPTURE_INPUT_EDGE) || at(parAddr, `PCU_OFS_SECOND_CAPTURE_INPUT_EDGE)) &&
               parWdata[15:1] != 15'h0000);
         end else begin
            parError <= 1'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_cancel;
      @(posedge sys_clk) disable iff (!resetn)
      (act2Wr && parWdata[1:0] == 2'h0) |=> capture2Mode == 2'h0;
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel did not stop capture");

   property p_arm_cont;
      @(posedge sys_clk) disable iff (!resetn)
      (act2Wr && parWdata[1:0] == 2'h2 && fieldbusMode) |=> capture2Mode == 2'h2;
   endproperty
   a_arm_cont: assert property (p_arm_cont) else $error("continuous not started");

   property p_once_ends;
      @(posedge sys_clk) disable iff (!resetn)
      (capture2Mode == 2'h1 && c2.count == 16'h0000 ##1 c2.count == 16'h0001 && !$past(act2Wr))
         |-> capture2Mode == 2'h0;
   endproperty
   a_once_ends: assert property (p_once_ends) else $error("single shot kept running");

   property p_no_arm;
      @(posedge sys_clk) disable iff (!resetn)
      (parWrite && !fieldbusMode && capture2Mode == 2'h0) |=> capture2Mode == 2'h0;
   endproperty
   a_no_arm: assert property (p_no_arm) else $error("armed outside fieldbus mode");

   property p_edge_fall;
      @(posedge sys_clk) disable iff (!resetn)
      (!$past(edgeSel2) && $rose(c2.count[0]))
         |-> $past(second_capture_input, 4) && !$past(second_capture_input, 3);
   endproperty
   a_edge_fall: assert property (p_edge_fall) else $error("falling edge not honoured");

   property p_count_clear;
      @(posedge sys_clk) disable iff (!resetn)
      c2.armAccepted |=> c2.count == 16'h0000 && c2.done == $past(u_second_capture_input.hit);
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("count not cleared");

   property p_latch;
      @(posedge sys_clk) disable iff (!resetn)
      (capture2Mode != 2'h0 && !act2Wr ##1 c2.count != $past(c2.count))
         |-> c2.position == $past(actualPosition) && c2.done;
   endproperty
   a_latch: assert property (p_latch) else $error("position not latched");

   property p_shift;
      @(posedge sys_clk) disable iff (!resetn)
      (posRefShiftValid && !u_second_capture_input.hit) |=>
         c2.position == POS_W'($past(c2.position) + $past(posRefShift));
   endproperty
   a_shift: assert property (p_shift) else $error("position not recomputed");

   property p_status;
      @(posedge sys_clk) disable iff (!resetn)
      (parRead && at(parAddr, `PCU_OFS_STATUS)) |=>
         parRdata[2:0] == {$past(indexDone), $past(c2.done), $past(c1.done)};
   endproperty
   a_status: assert property (p_status) else $error("status word wrong");

   property p_unit1_clear;
      @(posedge sys_clk) disable iff (!resetn)
      c1.armAccepted |=> c1.count == 16'h0000;
   endproperty
   a_unit1_clear: assert property (p_unit1_clear) else $error("unit 1 count not cleared");

   property p_sync_delay;
      @(posedge sys_clk) disable iff (!resetn)
      (capture2Mode == 2'h2 && $past(edgeSel2) && $rose(c2.count[0]))
         |-> !$past(second_capture_input, 4) && $past(second_capture_input, 3);
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("capture latency wrong");
endmodule

//--- rtl/pcu_map.svh
// register offsets, reset values and field codes of the position capture unit
`ifndef PCU_MAP_SVH
`define PCU_MAP_SVH
`define PCU_OFS_STATUS 16'h0A02
`define PCU_OFS_FIRST_CAPTURE_INPUT_EDGE 16'h0A04
`define PCU_OFS_SECOND_CAPTURE_INPUT_EDGE 16'h0A06
`define PCU_OFS_FIRST_CAPTURE_INPUT_ACT 16'h0A08
`define PCU_OFS_SECOND_CAPTURE_INPUT_ACT 16'h0A0A
`define PCU_OFS_FIRST_CAPTURE_INPUT_POS 16'h0A0C
`define PCU_OFS_SECOND_CAPTURE_INPUT_POS 16'h0A0E
`define PCU_OFS_FIRST_CAPTURE_INPUT_CNT 16'h0A10
`define PCU_OFS_SECOND_CAPTURE_INPUT_CNT 16'h0A12
`define PCU_RST_EDGE 1'h0
`define PCU_RST_STATUS 3'h0
`define PCU_BIT_FIRST_CAPTURE_INPUT 0
`define PCU_BIT_SECOND_CAPTURE_INPUT 1
`define PCU_BIT_INDEX 2
`define PCU_CODE_STOP 16'h0000
`define PCU_CODE_ONCE 16'h0001
`define PCU_CODE_CONT 16'h0002
`define PCU_EDGE_FALL 1'h0
`define PCU_EDGE_RISE 1'h1
`endif

//--- rtl/pcu_pkg.sv
// types of the position capture unit
package pcu_pkg;
   typedef enum logic [1:0] {
      PCU_IDLE = 2'h0,
      PCU_ONCE = 2'h1,
      PCU_CONT = 2'h3
   } pcu_mode_e;
   typedef logic [1:0] pcu_code_t;
endpackage

//--- rtl/pcu_chan_if.sv
// carrier between register side and one capture channel
`timescale 1ns/10ps
interface pcu_chan_if #(parameter int POS_W = 32, parameter int CNT_W = 16);
   logic activateWr;
   pcu_pkg::pcu_code_t activateCode;
   logic fieldbusMode;
   logic edgeSel;
   logic capIn;
   logic signed [POS_W-1:0] actualPos;
   logic shiftValid;
   logic signed [POS_W-1:0] shift;
   logic signed [POS_W-1:0] position;
   logic [CNT_W-1:0] count;
   logic done;
   pcu_pkg::pcu_code_t modeCode;
   logic armAccepted;
   modport chan (input activateWr, activateCode, fieldbusMode, edgeSel, capIn, actualPos,
      shiftValid, shift, output position, count, done, modeCode, armAccepted);
   modport ctrl (output activateWr, activateCode, fieldbusMode, edgeSel, capIn, actualPos,
      shiftValid, shift, input position, count, done, modeCode, armAccepted);
endinterface

//--- rtl/pcu_capture_channel.sv
// one capture channel: input sync, edge detect, latch, counter
`timescale 1ns/10ps
`include "pcu_map.svh"
module pcu_capture_channel #(
   parameter int POS_W = 32,
   parameter int CNT_W = 16
) (
   input wire logic sys_clk,
   input wire logic resetn,
   pcu_chan_if.chan ch
);
   pcu_pkg::pcu_mode_e mode;
   pcu_pkg::pcu_mode_e next_mode;
   logic capMeta;
   logic capSync;
   logic capPrev;
   logic hit;
   logic armOk;

   // ------------------------------------------------------------
   // input synchroniser
   // ------------------------------------------------------------
   // two flops then edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         capMeta <= 1'h0;
         capSync <= 1'h0;
         capPrev <= 1'h0;
      end else begin
         capMeta <= ch.capIn;
         capSync <= capMeta;
         capPrev <= capSync;
      end
   end

   assign hit = (mode != pcu_pkg::PCU_IDLE) &&
      ((ch.edgeSel == `PCU_EDGE_RISE) ? (capSync & ~capPrev) : (~capSync & capPrev));
   assign armOk = ch.activateWr && ch.fieldbusMode &&
      (ch.activateCode == 2'h1 || ch.activateCode == 2'h2);
   assign ch.armAccepted = armOk;

   // ------------------------------------------------------------
   // mode
   // ------------------------------------------------------------
   always_comb begin
      next_mode = mode;
      if (ch.activateWr && ch.activateCode == 2'h0) begin
         next_mode = pcu_pkg::PCU_IDLE;
      end else if (armOk) begin
         next_mode = (ch.activateCode == 2'h1) ? pcu_pkg::PCU_ONCE : pcu_pkg::PCU_CONT;
      end else begin
         case (mode)
            pcu_pkg::PCU_ONCE: begin
               if (hit) begin
                  next_mode = pcu_pkg::PCU_IDLE;
               end
            end
            pcu_pkg::PCU_CONT: next_mode = pcu_pkg::PCU_CONT;
            pcu_pkg::PCU_IDLE: next_mode = pcu_pkg::PCU_IDLE;
            default: next_mode = pcu_pkg::PCU_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode <= pcu_pkg::PCU_IDLE;
      end else begin
         mode <= next_mode;
      end
   end

   assign ch.modeCode = (mode == pcu_pkg::PCU_CONT) ? 2'h2 :
      (mode == pcu_pkg::PCU_ONCE) ? 2'h1 : 2'h0;

   // ------------------------------------------------------------
   // counter, position, done flag
   // ------------------------------------------------------------
   // clear on arm, count hits
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ch.count <= '0;
      end else if (armOk) begin
         ch.count <= '0;
      end else if (hit) begin
         ch.count <= ch.count + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ch.position <= '0;
      end else if (hit) begin
         ch.position <= ch.actualPos;
      end else if (ch.shiftValid) begin
         ch.position <= ch.position + ch.shift;
      end
   end

   // set wins over clear on arm
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ch.done <= 1'h0;
      end else if (hit) begin
         ch.done <= 1'h1;
      end else if (armOk) begin
         ch.done <= 1'h0;
      end
   end
endmodule

//--- sim/pcu_field_model.sv
// drive side model: capture input levels and actual position source
`timescale 1ns/10ps
module pcu_field_model (
   output logic capIn1,
   output logic capIn2,
   output logic signed [31:0] actualPos,
   input wire logic sys_clk
);
   initial begin
      capIn1 = 1'h0;
      capIn2 = 1'h0;
      actualPos = 32'sh0;
   end
   task automatic set_pos(input logic signed [31:0] p);
      @(posedge sys_clk) #1;
      actualPos = p;
   endtask
   task automatic drive_level(input int unit, input logic lvl);
      @(posedge sys_clk) #1;
      if (unit == 1) begin
         capIn1 = lvl;
      end else begin
         capIn2 = lvl;
      end
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
endmodule

//--- sim/tb_position_capture_unit.sv
// self-checking bench of the position capture unit
`timescale 1ns/10ps
`include "pcu_map.svh"
module tb_position_capture_unit;
   logic sys_clk = 1'h0;
   logic resetn = 1'h0;
   logic [15:0] parAddr = 16'h0;
   logic parWrite = 1'h0;
   logic parRead = 1'h0;
   logic [31:0] parWdata = 32'h0;
   logic [31:0] parRdata;
   logic parAck;
   logic parError;
   logic capIn1;
   logic capIn2;
   logic indexCaptureDone = 1'h0;
   logic fieldbusMode = 1'h0;
   logic signed [31:0] actualPos;
   logic posRefShiftValid = 1'h0;
   logic signed [31:0] posRefShift = 32'sh0;
   logic [1:0] capture1Mode;
   logic [1:0] capture2Mode;
   int err_total = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] rdVal;
   logic errVal;
   logic [15:0] expCnt;
   logic signed [31:0] expPos;
   logic signed [31:0] p;
   always #5 sys_clk = ~sys_clk;
   pcu_position_capture i_pcu_position_capture (.sys_clk(sys_clk), .resetn(resetn),
      .parAddr(parAddr), .parWrite(parWrite), .parRead(parRead), .parWdata(parWdata),
      .parRdata(parRdata), .parAck(parAck), .parError(parError),
      .first_capture_input(capIn1), .second_capture_input(capIn2),
      .indexCaptureDone(indexCaptureDone), .fieldbusMode(fieldbusMode),
      .actualPosition(actualPos), .posRefShiftValid(posRefShiftValid),
      .posRefShift(posRefShift), .capture1Mode(capture1Mode), .capture2Mode(capture2Mode));
   pcu_field_model i_pcu_field_model (.capIn1(capIn1), .capIn2(capIn2),
      .actualPos(actualPos), .sys_clk(sys_clk));
   // ----------------------------------------
   // compare, bus and expectation helpers
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk) #1;
      parAddr = a;
      parWdata = d;
      parWrite = wr;
      parRead = ~wr;
      @(posedge sys_clk) #1;
      parWrite = 1'h0;
      parRead = 1'h0;
      check({31'h0, parAck}, 32'h1);
      rdVal = parRdata;
      errVal = parError;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
      access(1'h0, a, 32'h0);
      check({31'h0, errVal}, 32'h0);
      check(rdVal, exp);
   endtask
   task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic expErr);
      access(1'h1, a, d);
      check({31'h0, errVal}, {31'h0, expErr});
   endtask
   task automatic pulse(input int unit, input logic lvl);
      i_pcu_field_model.drive_level(unit, lvl);
      i_pcu_field_model.drive_level(unit, ~lvl);
   endtask
   function automatic logic [15:0] next_count(input logic [15:0] c);
      return c + 16'h1;
   endfunction
   function automatic logic [31:0] shifted(input logic signed [31:0] a, input logic signed [31:0] s);
      return a + s;
   endfunction
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         complete_run();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rdVal = $urandom(32'h31E6);
      repeat (5) @(posedge sys_clk);
      #1;
      resetn = 1'h1;
      rd_chk(`PCU_OFS_STATUS, 32'h0);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_EDGE, 32'h0);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, 32'h0);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_CNT, 32'h0);
      wr_chk(`PCU_OFS_STATUS, 32'h1, 1'h1);
      access(1'h0, 16'h0A00, 32'h0);
      check({31'h0, errVal}, 32'h1);
      check(rdVal, 32'h0);
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_EDGE, 32'h2, 1'h1);
      // master keeps arming to fieldbus mode except this refusal probe
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, `PCU_CODE_ONCE, 1'h1);
      check({30'h0, capture2Mode}, 32'h0);
      fieldbusMode = 1'h1;
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, 32'h3, 1'h1);
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_EDGE, `PCU_EDGE_RISE, 1'h0);
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, `PCU_CODE_CONT, 1'h0);
      check({30'h0, capture2Mode}, 32'h2);
      expCnt = 16'h0;
      for (int i = 0; i < 6; i++) begin
         p = $urandom;
         i_pcu_field_model.set_pos(p);
         pulse(2, 1'h1);
         expCnt = next_count(expCnt);
         expPos = p;
         rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_POS, expPos);
         rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_CNT, {16'h0, expCnt});
      end
      rd_chk(`PCU_OFS_STATUS, 32'h2);
      p = $urandom;
      @(posedge sys_clk) #1;
      posRefShiftValid = 1'h1;
      posRefShift = p;
      @(posedge sys_clk) #1;
      posRefShiftValid = 1'h0;
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_POS, shifted(expPos, p));
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, `PCU_CODE_CONT, 1'h0);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_CNT, 32'h0);
      rd_chk(`PCU_OFS_STATUS, 32'h0);
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_EDGE, `PCU_EDGE_FALL, 1'h0);
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, `PCU_CODE_ONCE, 1'h0);
      p = $urandom;
      i_pcu_field_model.set_pos(p);
      pulse(2, 1'h1);
      check({30'h0, capture2Mode}, 32'h0);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, 32'h0);
      i_pcu_field_model.set_pos(p + 32'sh5);
      pulse(2, 1'h1);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_CNT, 32'h1);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_POS, p);
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, `PCU_CODE_CONT, 1'h0);
      wr_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_ACT, `PCU_CODE_STOP, 1'h0);
      check({30'h0, capture2Mode}, 32'h0);
      pulse(2, 1'h1);
      rd_chk(`PCU_OFS_SECOND_CAPTURE_INPUT_CNT, 32'h0);
      wr_chk(`PCU_OFS_FIRST_CAPTURE_INPUT_EDGE, `PCU_EDGE_RISE, 1'h0);
      wr_chk(`PCU_OFS_FIRST_CAPTURE_INPUT_ACT, `PCU_CODE_CONT, 1'h0);
      p = $urandom;
      i_pcu_field_model.set_pos(p);
      pulse(1, 1'h1);
      pulse(1, 1'h1);
      rd_chk(`PCU_OFS_FIRST_CAPTURE_INPUT_CNT, 32'h2);
      rd_chk(`PCU_OFS_FIRST_CAPTURE_INPUT_POS, p);
      rd_chk(`PCU_OFS_STATUS, 32'h1);
      indexCaptureDone = 1'h1;
      rd_chk(`PCU_OFS_STATUS, 32'h5);
      wr_chk(`PCU_OFS_FIRST_CAPTURE_INPUT_ACT, `PCU_CODE_ONCE, 1'h0);
      rd_chk(`PCU_OFS_FIRST_CAPTURE_INPUT_CNT, 32'h0);
      check({30'h0, capture1Mode}, 32'h1);
      complete_run();
   end
endmodule
